// >>> logic/pmc_top.sv
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
// Summary of operation
// - normal mode: core and enabled peripherals clocked and working
// - idle bit halts core, peripherals stay clocked, any interrupt wakes
// - suspend bit in power config register enters suspend
// - suspend halts core and peripherals, stops oscillators; five wake sources
// - stop bit powers down nets, pins hold, only reset exits
// - software disables analog first; sleep bit powers down most nets
// - sleep keeps pins, ram, registers; rtc, port match, comparator wake
// - after reset clock runs from low-power oscillator divided by 8
// - divider offers ratios 1 to 128 in powers of two
// - unused digital peripherals have their clocks gated off
module pmc_top
	import pmc_pkg::*;
#(
	parameter int NPERIPH = PMC_NPERIPH
) (
	input  wire logic              clk,
	input  wire logic              sys_rst,
	input  wire logic [3:0]        reg_addr,
	input  wire logic [7:0]        reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic [7:0]             reg_rdata,
	input  wire pmc_pkg::pmc_wake_s wake_in,
	output pmc_pkg::pmc_power_s    power_out,
	output logic [1:0]             clk_src_sel,
	output logic                   system_clock_tick,
	output logic                   mode_suspend_active,
	output logic                   mode_stop_active,
	output logic                   mode_sleep_active
);
	import pmc_pkg::*;

	pmc_mode_e              mode_ff;
	pmc_mode_e              nxt_mode;
	logic                   idle_req_ff;
	logic                   stop_req_ff;
	logic                   suspend_req_ff;
	logic                   sleep_req_ff;
	logic [2:0]             div_sel_ff;
	logic [1:0]             src_sel_ff;
	logic [NPERIPH-1:0]     periph_en_ff;
	logic [PMC_NWAKE-1:0]   wake_flags_ff;
	logic [PMC_NWAKE-1:0]   wake_meta_ff;
	logic [PMC_NWAKE-1:0]   wake_sync_ff;
	logic                   cmp0_prev_ff;
	logic                   cmp0_rise;
	logic                   wake_idle;
	logic                   wake_susp;
	logic                   wake_sleep;
	logic                   wake_now;
	logic                   wr_pwr;
	logic                   wr_cfg;
	logic                   core_run;
	logic [7:0]             nxt_rdata;

	// wake pins come from other domains: two-stage synchroniser
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wake_meta_ff <= '0;
			wake_sync_ff <= '0;
		end else begin
			wake_meta_ff <= wake_in;
			wake_sync_ff <= wake_meta_ff;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cmp0_prev_ff <= 1'b0;
		end else begin
			cmp0_prev_ff <= wake_sync_ff[PMC_NWAKE-1-PMC_WK_CMP0_RISE];
		end
	end

	// struct order puts rtc_alarm in the top bit, so reindex
	logic s_alarm;
	logic s_fail;
	logic s_cs;
	logic s_pm;
	logic s_irq;
	assign s_alarm   = wake_sync_ff[PMC_NWAKE-1-PMC_WK_RTC_ALARM];
	assign s_fail    = wake_sync_ff[PMC_NWAKE-1-PMC_WK_RTC_FAIL];
	assign s_cs      = wake_sync_ff[PMC_NWAKE-1-PMC_WK_CAPSENSE];
	assign s_pm      = wake_sync_ff[PMC_NWAKE-1-PMC_WK_PORTMATCH];
	assign s_irq     = wake_sync_ff[PMC_NWAKE-1-PMC_WK_IRQ];
	assign cmp0_rise = wake_sync_ff[PMC_NWAKE-1-PMC_WK_CMP0_RISE] & ~cmp0_prev_ff;

	assign wake_idle  = s_irq;
	assign wake_susp  = s_alarm | s_fail | s_cs | s_pm | cmp0_rise;
	assign wake_sleep = s_alarm | s_fail | s_pm | cmp0_rise;

	always_comb begin
		case (mode_ff)
			PMC_IDLE:    wake_now = wake_idle;
			PMC_SUSPEND: wake_now = wake_susp;
			PMC_SLEEP:   wake_now = wake_sleep;
			default:     wake_now = 1'b0;
		endcase
	end

	assign wr_pwr = reg_wr && (reg_addr == PMC_ADDR_PWR_CTRL);
	assign wr_cfg = reg_wr && (reg_addr == PMC_ADDR_PMU_CFG);

	// requests are taken only in normal mode; wake clears the idle, suspend and sleep requests
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			idle_req_ff    <= 1'b0;
			stop_req_ff    <= 1'b0;
			suspend_req_ff <= 1'b0;
			sleep_req_ff   <= 1'b0;
		end else if (wake_now) begin
			idle_req_ff    <= 1'b0;
			suspend_req_ff <= 1'b0;
			sleep_req_ff   <= 1'b0;
		end else if (mode_ff == PMC_NORMAL) begin
			if (wr_pwr) begin
				idle_req_ff <= reg_wdata[PMC_BIT_IDLE];
				stop_req_ff <= reg_wdata[PMC_BIT_STOP];
			end
			if (wr_cfg) begin
				suspend_req_ff <= reg_wdata[PMC_BIT_SUSPEND];
				sleep_req_ff   <= reg_wdata[PMC_BIT_SLEEP];
			end
		end
	end

	// stop wins, then sleep, suspend, idle
	always_comb begin
		nxt_mode = mode_ff;
		case (mode_ff)
			PMC_NORMAL: begin
				if (stop_req_ff) begin
					nxt_mode = PMC_STOP;
				end else if (sleep_req_ff) begin
					nxt_mode = PMC_SLEEP;
				end else if (suspend_req_ff) begin
					nxt_mode = PMC_SUSPEND;
				end else if (idle_req_ff) begin
					nxt_mode = PMC_IDLE;
				end
			end
			PMC_IDLE, PMC_SUSPEND, PMC_SLEEP: begin
				if (wake_now) begin
					nxt_mode = PMC_NORMAL;
				end
			end
			PMC_STOP: nxt_mode = PMC_STOP;
			default:  nxt_mode = PMC_NORMAL;
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mode_ff <= PMC_NORMAL;
		end else begin
			mode_ff <= nxt_mode;
		end
	end

	// clock selection; held while core halted
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			div_sel_ff <= PMC_DIV_RST;
			src_sel_ff <= PMC_SRC_RST;
		end else if (reg_wr && reg_addr == PMC_ADDR_CLK_SEL && mode_ff == PMC_NORMAL) begin
			div_sel_ff <= reg_wdata[PMC_DIV_LSB +: 3];
			src_sel_ff <= reg_wdata[PMC_SRC_LSB +: 2];
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			periph_en_ff <= '0;
		end else if (reg_wr && reg_addr == PMC_ADDR_PERIPH_EN && mode_ff == PMC_NORMAL) begin
			periph_en_ff <= reg_wdata[NPERIPH-1:0];
		end
	end

	// sticky record of every wake cause since the flags were cleared; set beats clear
	logic [PMC_NWAKE-1:0] wake_cause;
	assign wake_cause = {mode_ff == PMC_IDLE && s_irq,
		wake_now && cmp0_rise, wake_now && s_pm,
		mode_ff == PMC_SUSPEND && s_cs, wake_now && s_fail,
		wake_now && s_alarm};
	logic [PMC_NWAKE-1:0] wake_clr;
	assign wake_clr = (reg_wr && reg_addr == PMC_ADDR_WAKE_FLAGS)
		? reg_wdata[PMC_NWAKE-1:0] : '0;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wake_flags_ff <= '0;
		end else begin
			wake_flags_ff <= (wake_flags_ff & ~wake_clr) | wake_cause;
		end
	end

	always_comb begin
		case (reg_addr)
			PMC_ADDR_PWR_CTRL:   nxt_rdata = {6'h00, stop_req_ff, idle_req_ff};
			PMC_ADDR_PMU_CFG:    nxt_rdata = {6'h00, sleep_req_ff, suspend_req_ff};
			PMC_ADDR_CLK_SEL:    nxt_rdata = {2'h0, src_sel_ff, 1'b0, div_sel_ff};
			PMC_ADDR_PERIPH_EN:  nxt_rdata = 8'(periph_en_ff);
			PMC_ADDR_STATUS:     nxt_rdata = {5'h00, mode_ff};
			PMC_ADDR_WAKE_FLAGS: nxt_rdata = {2'h0, wake_flags_ff};
			default:             nxt_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= nxt_rdata;
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	assign core_run = (mode_ff == PMC_NORMAL);

	pmc_clk_div #(
		.DIV_W (PMC_DIV_W)
	) u_div (
		.clk     (clk),
		.sys_rst (sys_rst),
		.run     (core_run || mode_ff == PMC_IDLE),
		.div_sel (div_sel_ff),
		.tick    (system_clock_tick)
	);

	// power and clock controls, all registered
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			power_out.core_clk_en   <= 1'b1;
			power_out.periph_clk_en <= '0;
			power_out.hfosc_en      <= 1'b0;
			power_out.lposc_en      <= 1'b1;
			power_out.main_pwr_en   <= 1'b1;
			power_out.pin_retain    <= 1'b0;
			clk_src_sel             <= PMC_SRC_RST;
		end else begin
			power_out.core_clk_en <= (nxt_mode == PMC_NORMAL);
			case (nxt_mode)
				PMC_NORMAL, PMC_IDLE: begin
					power_out.periph_clk_en <= PMC_NPERIPH'(periph_en_ff);
				end
				default: power_out.periph_clk_en <= '0;
			endcase
			power_out.hfosc_en <= (src_sel_ff == PMC_SRC_HFOSC) &&
				(nxt_mode == PMC_NORMAL || nxt_mode == PMC_IDLE);
			power_out.lposc_en <= (src_sel_ff == PMC_SRC_LPOSC) &&
				(nxt_mode == PMC_NORMAL || nxt_mode == PMC_IDLE);
			power_out.main_pwr_en <= !(nxt_mode == PMC_STOP ||
				nxt_mode == PMC_SLEEP);
			power_out.pin_retain  <= (nxt_mode == PMC_STOP ||
				nxt_mode == PMC_SLEEP);
			clk_src_sel <= src_sel_ff;
		end
	end

	assign mode_suspend_active = (mode_ff == PMC_SUSPEND);
	assign mode_stop_active    = (mode_ff == PMC_STOP);
	assign mode_sleep_active   = (mode_ff == PMC_SLEEP);
endmodule

// >>> logic/pmc_pkg.sv
package pmc_pkg;
	// register map (word index on the plain register port)
	localparam logic [3:0] PMC_ADDR_PWR_CTRL   = 4'h0;
	localparam logic [3:0] PMC_ADDR_PMU_CFG    = 4'h1;
	localparam logic [3:0] PMC_ADDR_CLK_SEL    = 4'h2;
	localparam logic [3:0] PMC_ADDR_PERIPH_EN  = 4'h3;
	localparam logic [3:0] PMC_ADDR_STATUS     = 4'h4;
	localparam logic [3:0] PMC_ADDR_WAKE_FLAGS = 4'h5;
	// power control register fields
	localparam int PMC_BIT_IDLE    = 0;
	localparam int PMC_BIT_STOP    = 1;
	// power management config register fields
	localparam int PMC_BIT_SUSPEND = 0;
	localparam int PMC_BIT_SLEEP   = 1;
	// clock select register fields
	localparam int PMC_DIV_LSB     = 0;
	localparam int PMC_SRC_LSB     = 4;
	// clock sources
	localparam logic [1:0] PMC_SRC_LPOSC = 2'h0;
	localparam logic [1:0] PMC_SRC_HFOSC = 2'h1;
	localparam logic [1:0] PMC_SRC_LFOSC = 2'h2;
	localparam logic [1:0] PMC_SRC_EXT   = 2'h3;
	// reset values, peripheral count and divider width
	localparam logic [2:0] PMC_DIV_RST   = 3'h3;
	localparam logic [1:0] PMC_SRC_RST   = PMC_SRC_LPOSC;
	localparam int PMC_NPERIPH           = 8;
	localparam int PMC_DIV_W             = 7;
	// wake flag positions
	localparam int PMC_WK_RTC_ALARM = 0;
	localparam int PMC_WK_RTC_FAIL  = 1;
	localparam int PMC_WK_CAPSENSE  = 2;
	localparam int PMC_WK_PORTMATCH = 3;
	localparam int PMC_WK_CMP0_RISE = 4;
	localparam int PMC_WK_IRQ       = 5;
	localparam int PMC_NWAKE        = 6;

	typedef enum logic [2:0] {
		PMC_NORMAL,
		PMC_IDLE,
		PMC_SUSPEND,
		PMC_STOP,
		PMC_SLEEP
	} pmc_mode_e;

	typedef struct packed {
		logic       rtc_alarm;
		logic       rtc_fail;
		logic       capsense_irq;
		logic       port_match;
		logic       cmp0_out;
		logic       any_irq;
	} pmc_wake_s;

	typedef struct packed {
		logic                     core_clk_en;
		logic [PMC_NPERIPH-1:0]   periph_clk_en;
		logic                     hfosc_en;
		logic                     lposc_en;
		logic                     main_pwr_en;
		logic                     pin_retain;
	} pmc_power_s;
endpackage

// >>> logic/pmc_clk_div.sv
`timescale 1ns/1ps
module pmc_clk_div #(
	parameter int DIV_W = 7
) (
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       run,
	input  wire logic [2:0] div_sel,
	output logic            tick
);
	logic [DIV_W-1:0] cnt_ff;
	logic [DIV_W-1:0] mask;

	// ratio 2**div_sel: tick when the low div_sel bits all set
	assign mask = DIV_W'((8'h01 << div_sel) - 8'h01);

	always_ff @(posedge clk) begin
		if (sys_rst || !run) begin
			cnt_ff <= '0;
		end else begin
			cnt_ff <= cnt_ff + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst || !run) begin
			tick <= 1'b0;
		end else begin
			tick <= ((cnt_ff & mask) == mask);
		end
	end
endmodule

// >>> sim/pmc_chk_sva.sv
`timescale 1ns/1ps
module pmc_chk_sva
	import pmc_pkg::*;
(
	input wire logic               clk,
	input wire logic               sys_rst,
	input wire logic [3:0]         reg_addr,
	input wire logic [7:0]         reg_wdata,
	input wire logic               reg_wr,
	input wire pmc_pkg::pmc_wake_s  wake_in,
	input wire pmc_pkg::pmc_power_s power_out,
	input wire logic [1:0]         clk_src_sel,
	input wire logic               system_clock_tick,
	input wire logic               mode_suspend_active,
	input wire logic               mode_stop_active,
	input wire logic               mode_sleep_active
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	wire nrm = power_out.core_clk_en && !mode_suspend_active && !mode_stop_active
		&& !mode_sleep_active;
	// accepted mode request: two low bits of the written byte
	sequence s_wr(a, m);
		reg_wr && reg_addr == a && reg_wdata[1:0] == m && nrm;
	endsequence
	property p_rst;
		$fell(sys_rst) |-> power_out.core_clk_en && power_out.lposc_en
			&& power_out.main_pwr_en && !power_out.hfosc_en
			&& power_out.periph_clk_en == '0 && clk_src_sel == PMC_SRC_LPOSC;
	endproperty
	a_rst: assert property (p_rst) else $error("reset outputs wrong");
	property p_norm;
		nrm |-> power_out.main_pwr_en && !power_out.pin_retain;
	endproperty
	a_norm: assert property (p_norm) else $error("normal mode unpowered");
	property p_idle_in;
		s_wr(PMC_ADDR_PWR_CTRL, 2'h1) |-> ##[1:2] !power_out.core_clk_en
			##0 $stable(power_out.periph_clk_en) ##0 power_out.main_pwr_en;
	endproperty
	a_idle_in: assert property (p_idle_in) else $error("idle entry wrong");
	property p_stop_in;
		s_wr(PMC_ADDR_PWR_CTRL, 2'h2) |-> ##[1:2] mode_stop_active;
	endproperty
	a_stop_in: assert property (p_stop_in) else $error("stop not entered");
	property p_stop_hold;
		mode_stop_active |=> mode_stop_active && !power_out.main_pwr_en
			&& power_out.pin_retain;
	endproperty
	a_stop_hold: assert property (p_stop_hold) else $error("stop left");
	property p_susp_in;
		s_wr(PMC_ADDR_PMU_CFG, 2'h1) |-> ##[1:2] mode_suspend_active;
	endproperty
	a_susp_in: assert property (p_susp_in) else $error("suspend not entered");
	property p_sleep_in;
		s_wr(PMC_ADDR_PMU_CFG, 2'h2) |-> ##[1:2] mode_sleep_active;
	endproperty
	a_sleep_in: assert property (p_sleep_in) else $error("sleep not entered");
	property p_susp_pw;
		mode_suspend_active && $past(mode_suspend_active) |-> !power_out.core_clk_en
			&& !power_out.hfosc_en && !power_out.lposc_en
			&& power_out.periph_clk_en == '0 && !system_clock_tick;
	endproperty
	a_susp_pw: assert property (p_susp_pw) else $error("suspend not halted");
	property p_sleep_pw;
		mode_sleep_active && $past(mode_sleep_active) |-> !power_out.main_pwr_en
			&& power_out.pin_retain && !system_clock_tick;
	endproperty
	a_sleep_pw: assert property (p_sleep_pw) else $error("sleep power wrong");
	property p_susp_wk;
		mode_suspend_active && wake_in.port_match |-> ##[1:4] nrm;
	endproperty
	a_susp_wk: assert property (p_susp_wk) else $error("no suspend wake");
endmodule
bind pmc_top pmc_chk_sva chk_u (.*);

// >>> sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import pmc_pkg::*;
	logic       clk, sys_rst, reg_wr, reg_rd, tick, susp, stp, slp;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata;
	logic [1:0] src;
	pmc_wake_s  wake_in;
	pmc_power_s power_out;
	int         num_errors, cmp_count, cyc, n;
	wire [7:0]  pw = {3'h0, power_out.core_clk_en, power_out.hfosc_en, power_out.lposc_en,
		power_out.main_pwr_en, power_out.pin_retain};
	wire [7:0]  md = {5'h0, susp, stp, slp};
	pmc_top dut_u (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wake_in(wake_in),
		.power_out(power_out), .clk_src_sel(src), .system_clock_tick(tick),
		.mode_suspend_active(susp), .mode_stop_active(stp), .mode_sleep_active(slp));
	initial begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			num_errors++;
			wrap_up();
		end
	end
	task wrap_up;
		if (num_errors == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task chk(input logic [7:0] s, input logic [7:0] e);
		cmp_count++;
		if (s !== e) begin
			num_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task tk(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task wk(input logic [5:0] v);
		@(posedge clk);
		wake_in <= v;
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
	endtask
	task rst;
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		tk(1);
	endtask
	// cycles between two ticks
	task per(output int p);
		int k;
		k = 0;
		p = 0;
		tk(2);
		while (tick !== 1'b1 && k < 300) begin
			tk(1);
			k++;
		end
		do begin
			tk(1);
			p++;
		end while (tick !== 1'b1 && p < 300);
	endtask
	task t_reset;
		chk(pw, 8'h16);
		chk({6'h0, src}, {6'h0, PMC_SRC_LPOSC});
		chk(power_out.periph_clk_en, 8'h00);
		rd(PMC_ADDR_CLK_SEL, 8'h03);
		per(n);
		chk(8'(n), 8'h08);
		rd(4'hf, 8'h00);
	endtask
	task t_div;
		for (int d = 0; d < 8; d++) begin
			wr(PMC_ADDR_CLK_SEL, 8'(d) | 8'h10);
			per(n);
			chk(8'(n), 8'(1 << d));
		end
		chk({6'h0, src}, {6'h0, PMC_SRC_HFOSC});
		wr(PMC_ADDR_CLK_SEL, 8'h03);
	endtask
	task t_periph;
		wr(PMC_ADDR_PERIPH_EN, 8'ha5);
		wr(4'hf, 8'hff);
		tk(2);
		chk(power_out.periph_clk_en, 8'ha5);
		rd(PMC_ADDR_PERIPH_EN, 8'ha5);
	endtask
	task t_idle;
		wr(PMC_ADDR_PWR_CTRL, 8'h01);
		tk(2);
		chk(pw, 8'h06);
		chk(power_out.periph_clk_en, 8'ha5);
		rd(PMC_ADDR_STATUS, 8'h01);
		wr(PMC_ADDR_PERIPH_EN, 8'h00);
		rd(PMC_ADDR_PERIPH_EN, 8'ha5);
		wk(6'h01);
		tk(6);
		chk(pw, 8'h16);
		rd(PMC_ADDR_PWR_CTRL, 8'h00);
		rd(PMC_ADDR_WAKE_FLAGS, 8'h20);
		wk(6'h00);
		wr(PMC_ADDR_WAKE_FLAGS, 8'h3f);
		rd(PMC_ADDR_WAKE_FLAGS, 8'h00);
	endtask
	// each wake input alone, msk says which ones end the mode
	task t_low(input logic [7:0] cfg, input logic [5:0] msk, input logic [7:0] epw,
		input logic [7:0] emd);
		for (int i = 0; i < 6; i++) begin
			wr(PMC_ADDR_PMU_CFG, cfg);
			tk(2);
			chk(md, emd);
			chk(pw, epw);
			wk(6'(1 << i));
			tk(6);
			chk(md, msk[i] ? 8'h00 : emd);
			wk(6'h04);
			tk(6);
			wk(6'h00);
			chk(pw, 8'h16);
			rd(PMC_ADDR_PMU_CFG, 8'h00);
			rd(PMC_ADDR_PERIPH_EN, 8'ha5);
			wr(PMC_ADDR_WAKE_FLAGS, 8'h3f);
		end
	endtask
	task t_stop;
		wr(PMC_ADDR_PWR_CTRL, 8'h02);
		tk(2);
		chk(md, 8'h02);
		chk(pw, 8'h01);
		wk(6'h3f);
		tk(8);
		chk(md, 8'h02);
		wk(6'h00);
		rst;
		chk(pw, 8'h16);
		rd(PMC_ADDR_STATUS, 8'h00);
	endtask
	initial begin
		sys_rst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		wake_in = '0;
		num_errors = 0;
		cmp_count = 0;
		cyc = 0;
		rst;
		t_reset;
		t_div;
		t_periph;
		t_idle;
		t_low(8'h01, 6'h3e, 8'h02, 8'h04);
		t_low(8'h02, 6'h36, 8'h01, 8'h01);
		t_stop;
		wrap_up;
	end
endmodule
